// >>> logic/mcce_pkg.sv
// Package for the machine-check cause encoder: cause codes, register map, timing.
// Assumes a single 100 MHz core clock domain.
package mcce_pkg;
  // Cause codes placed in the frame code field
  localparam logic [7:0] MCCE_MM_STATUS_UNKNOWN_CAUSE = 8'h01;
  localparam logic [7:0] MCCE_BAD_IRQ_ID_CAUSE = 8'h02;
  localparam logic [7:0] MCCE_IMPOSSIBLE_DISPATCH_CAUSE = 8'h03;
  localparam logic [7:0] MCCE_STRING_MOVE_STATE_CAUSE = 8'h04;
  localparam logic [7:0] MCCE_ASYNC_FAULT_CAUSE = 8'h05;
  localparam logic [7:0] MCCE_SYNC_FAULT_CAUSE = 8'h06;
  localparam logic [7:0] MCCE_NO_CAUSE = 8'h00;
  // Frame longword field positions
  localparam int MCCE_CODE_LSB = 16;
  localparam int MCCE_CODE_MSB = 23;
  localparam int MCCE_RESTART_SAFE_BIT = 7;
  // String move state encodings
  localparam logic [1:0] MCCE_MOVE_FWD = 2'h0;
  localparam logic [1:0] MCCE_MOVE_BWD = 2'h1;
  localparam logic [1:0] MCCE_MOVE_FILL = 2'h2;
  localparam logic [1:0] MCCE_MOVE_ILLEGAL = 2'h3;
  // Number of legal interrupt ids (0 .. limit-1)
  localparam logic [5:0] MCCE_IRQ_ID_LIMIT = 6'h20;
  // Register byte offsets
  localparam logic [7:0] MCCE_REG_CAUSE = 8'h00;
  localparam logic [7:0] MCCE_REG_STATUS = 8'h04;
  localparam logic [7:0] MCCE_REG_MASK = 8'h08;
  localparam logic [7:0] MCCE_REG_FLAGS = 8'h0c;
  localparam logic [7:0] MCCE_REG_TIMEOUT = 8'h10;
  // Status/mask bit positions
  localparam int MCCE_ST_MCHK = 0;
  localparam int MCCE_ST_TBPAR = 1;
  localparam int MCCE_ST_STALL = 2;
  localparam int MCCE_ST_W = 3;
  // Flags register bit positions
  localparam int MCCE_FL_XLATE_LOCK = 0;
  localparam int MCCE_FL_STALL_TIMEOUT = 1;
  // Reset values
  localparam logic [2:0] MCCE_MASK_RESET = 3'h0;
  // Stall timeout: time in ns and derived cycle count
  localparam int MCCE_CLK_PERIOD_NS = 10;
  localparam int MCCE_STALL_TIMEOUT_NS = 20000;
  localparam int MCCE_STALL_TIMEOUT_CYC = MCCE_STALL_TIMEOUT_NS / MCCE_CLK_PERIOD_NS;
  localparam logic [1:0] MCCE_RESP_OKAY = 2'h0;
  localparam logic [1:0] MCCE_RESP_SLVERR = 2'h2;
endpackage : mcce_pkg

// >>> logic/mcce_stall_if.sv
// Interface between the cause encoder and its stall watchdog.
// Assumes both ends share clk_sys_i.
interface mcce_stall_if;
  logic stall_any;
  logic expired;
  modport ctrl (output stall_any, input expired);
  modport dog (input stall_any, output expired);
endinterface : mcce_stall_if

// >>> logic/mcce_stall_watchdog.sv
// Stall watchdog: pulses expired after a continuous stall on any of the four stall sources.
// Assumes stall_any is synchronous to clk_sys_i.
module mcce_stall_watchdog
  import mcce_pkg::*;
#(
  parameter int TIMEOUT_CYC = MCCE_STALL_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Stall link
  mcce_stall_if.dog stall_bus
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic expired_q;
  logic next_expired;

  always_comb begin
    next_count = 32'h0;
    next_expired = 1'b0;
    if (stall_bus.stall_any) begin
      if (count == 32'(TIMEOUT_CYC - 1)) begin
        next_expired = 1'b1;
      end else begin
        next_count = count + 32'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      count <= 32'h0;
      expired_q <= 1'b0;
    end else begin
      count <= next_count;
      expired_q <= next_expired;
    end
  end

  assign stall_bus.expired = expired_q;
endmodule : mcce_stall_watchdog

// >>> logic/mcce_cause_encoder.sv
// Machine-check cause encoder with AXI4-Lite status/control slave.
// Assumes detection inputs are synchronous to clk_sys_i and microcode
// asserts context qualifiers in the same cycle as the event.
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
module mcce_cause_encoder
  import mcce_pkg::*;
#(
  parameter int STALL_TIMEOUT_CYC = MCCE_STALL_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Memory-management probe
  input wire logic mm_probe_valid_i,
  input wire logic mm_probe_status_known_i,
  input wire logic mm_fault_active_i,
  // Interrupt processing
  input wire logic irq_id_valid_i,
  input wire logic [5:0] interrupt_summary_reg_i,
  input wire logic irq_between_instr_i,
  input wire logic irq_mid_instr_i,
  // Microcode dispatch and string move
  input wire logic impossible_dispatch_i,
  input wire logic string_move_instr_i,
  input wire logic [1:0] string_move_state_i,
  // Hardware errors
  input wire logic async_hw_error_i,
  input wire logic sync_hw_error_i,
  input wire logic xlate_hit_i,
  input wire logic xlate_tag_parity_err_i,
  input wire logic xlate_pte_parity_err_i,
  // Stalls
  input wire logic exec_stage_three_stall_i,
  input wire logic exec_stage_four_stall_i,
  input wire logic field_queue_stall_i,
  input wire logic instr_queue_stall_i,
  // Architectural state tracking
  input wire logic instr_start_i,
  input wire logic arch_state_write_i,
  // Frame outputs
  output logic mchk_o,
  output logic microtrap_o,
  output logic [7:0] mchk_code_o,
  output logic [31:0] frame_word1_o,
  output logic irq_o,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  function automatic logic reg_known(input logic [7:0] addr);
    reg_known = (addr == MCCE_REG_CAUSE) || (addr == MCCE_REG_STATUS) ||
                (addr == MCCE_REG_MASK) || (addr == MCCE_REG_FLAGS) ||
                (addr == MCCE_REG_TIMEOUT);
  endfunction : reg_known

  mcce_stall_if stall_bus ();

  mcce_stall_watchdog #(
    .TIMEOUT_CYC(STALL_TIMEOUT_CYC)
  ) u_watchdog (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .stall_bus(stall_bus)
  );

  assign stall_bus.stall_any = exec_stage_three_stall_i | exec_stage_four_stall_i |
                               field_queue_stall_i | instr_queue_stall_i;

  // Detection
  logic det_mm;
  logic det_irq;
  logic det_move;
  logic det_tbpar;
  logic [7:0] det_code;
  logic det_any;

  always_comb begin
    det_mm = mm_probe_valid_i & ~mm_probe_status_known_i & mm_fault_active_i;
    det_irq = irq_id_valid_i & (irq_between_instr_i | irq_mid_instr_i) &
              (interrupt_summary_reg_i >= MCCE_IRQ_ID_LIMIT);
    det_move = string_move_instr_i & (string_move_state_i == MCCE_MOVE_ILLEGAL);
    det_tbpar = xlate_hit_i & (xlate_tag_parity_err_i | xlate_pte_parity_err_i);
    det_code = MCCE_NO_CAUSE;
    // Async faults win: they interrupt microcode wherever it stands
    if (async_hw_error_i | det_tbpar | stall_bus.expired) begin
      det_code = MCCE_ASYNC_FAULT_CAUSE;
    end else if (sync_hw_error_i) begin
      det_code = MCCE_SYNC_FAULT_CAUSE;
    end else if (det_mm) begin
      det_code = MCCE_MM_STATUS_UNKNOWN_CAUSE;
    end else if (det_irq) begin
      det_code = MCCE_BAD_IRQ_ID_CAUSE;
    end else if (impossible_dispatch_i) begin
      det_code = MCCE_IMPOSSIBLE_DISPATCH_CAUSE;
    end else if (det_move) begin
      det_code = MCCE_STRING_MOVE_STATE_CAUSE;
    end
    det_any = (det_code != MCCE_NO_CAUSE);
  end

  // Frame state, flags and interrupt status
  logic [7:0] code;
  logic mchk_q;
  logic trap_q;
  logic state_clean;
  logic restart_safe;
  logic xlate_lock;
  logic stall_timeout_flag;
  logic [2:0] status;
  logic [2:0] mask;
  logic [7:0] next_code;
  logic next_mchk_q;
  logic next_trap_q;
  logic next_state_clean;
  logic next_restart_safe;
  logic next_xlate_lock;
  logic next_stall_timeout_flag;
  logic [2:0] next_status;
  logic [2:0] next_mask;
  logic [2:0] events;

  // AXI state
  typedef enum logic [2:0] {
    MCCE_W_IDLE = 3'b001,
    MCCE_W_HAVE = 3'b010,
    MCCE_W_RESP = 3'b100
  } mcce_wstate_t;
  mcce_wstate_t wstate;
  mcce_wstate_t next_wstate;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held;
  logic next_w_held;
  logic [7:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic [1:0] bresp;
  logic [1:0] next_bresp;
  logic rvalid;
  logic next_rvalid;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0] rresp;
  logic [1:0] next_rresp;
  logic wr_fire;

  assign wr_fire = (wstate == MCCE_W_HAVE);

  always_comb begin
    events = '0;
    events[MCCE_ST_MCHK] = det_any;
    events[MCCE_ST_TBPAR] = det_tbpar;
    events[MCCE_ST_STALL] = stall_bus.expired;
    next_code = code;
    next_mchk_q = det_any;
    next_trap_q = det_tbpar;
    next_state_clean = state_clean;
    next_restart_safe = restart_safe;
    next_xlate_lock = xlate_lock;
    next_stall_timeout_flag = stall_timeout_flag;
    next_status = status;
    next_mask = mask;
    if (instr_start_i) begin
      next_state_clean = ~arch_state_write_i;
    end else if (arch_state_write_i) begin
      next_state_clean = 1'b0;
    end
    if (det_any) begin
      next_code = det_code;
      next_restart_safe = state_clean & ~arch_state_write_i;
    end
    if (wr_fire && w_strb[0]) begin
      if (aw_addr == MCCE_REG_STATUS) begin
        next_status = status & ~w_data[2:0];
      end
      if (aw_addr == MCCE_REG_MASK) begin
        next_mask = w_data[2:0];
      end
      if (aw_addr == MCCE_REG_FLAGS) begin
        if (w_data[MCCE_FL_XLATE_LOCK]) begin
          next_xlate_lock = 1'b0;
        end
        if (w_data[MCCE_FL_STALL_TIMEOUT]) begin
          next_stall_timeout_flag = 1'b0;
        end
      end
    end
    // Set wins over a clear in the same cycle
    next_status = next_status | events;
    if (det_tbpar) begin
      next_xlate_lock = 1'b1;
    end
    if (stall_bus.expired) begin
      next_stall_timeout_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      code <= MCCE_NO_CAUSE;
      mchk_q <= 1'b0;
      trap_q <= 1'b0;
      state_clean <= 1'b1;
      restart_safe <= 1'b0;
      xlate_lock <= 1'b0;
      stall_timeout_flag <= 1'b0;
      status <= 3'h0;
      mask <= MCCE_MASK_RESET;
    end else begin
      code <= next_code;
      mchk_q <= next_mchk_q;
      trap_q <= next_trap_q;
      state_clean <= next_state_clean;
      restart_safe <= next_restart_safe;
      xlate_lock <= next_xlate_lock;
      stall_timeout_flag <= next_stall_timeout_flag;
      status <= next_status;
      mask <= next_mask;
    end
  end

  // Write channel: address and data accepted in either order
  always_comb begin
    next_wstate = wstate;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bresp = bresp;
    case (wstate)
      MCCE_W_IDLE: begin
        if (s_axi_awvalid_i && !aw_held) begin
          next_aw_held = 1'b1;
          next_aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !w_held) begin
          next_w_held = 1'b1;
          next_w_data = s_axi_wdata_i;
          next_w_strb = s_axi_wstrb_i;
        end
        if (next_aw_held && next_w_held) begin
          next_wstate = MCCE_W_HAVE;
        end
      end
      MCCE_W_HAVE: begin
        next_bresp = reg_known(aw_addr) ? MCCE_RESP_OKAY : MCCE_RESP_SLVERR;
        next_aw_held = 1'b0;
        next_w_held = 1'b0;
        next_wstate = MCCE_W_RESP;
      end
      MCCE_W_RESP: begin
        if (s_axi_bready_i) begin
          next_wstate = MCCE_W_IDLE;
        end
      end
      default: begin
        next_wstate = MCCE_W_IDLE;
      end
    endcase
  end

  // Read channel
  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid) begin
      if (s_axi_rready_i) begin
        next_rvalid = 1'b0;
      end
    end else if (s_axi_arvalid_i) begin
      next_rvalid = 1'b1;
      next_rresp = reg_known(s_axi_araddr_i) ? MCCE_RESP_OKAY : MCCE_RESP_SLVERR;
      case (s_axi_araddr_i)
        MCCE_REG_CAUSE: next_rdata = frame_word1_o;
        MCCE_REG_STATUS: next_rdata = {29'h0, status};
        MCCE_REG_MASK: next_rdata = {29'h0, mask};
        MCCE_REG_FLAGS: next_rdata = {30'h0, stall_timeout_flag, xlate_lock};
        MCCE_REG_TIMEOUT: next_rdata = 32'(STALL_TIMEOUT_CYC);
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      wstate <= MCCE_W_IDLE;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      bresp <= MCCE_RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= MCCE_RESP_OKAY;
    end else begin
      wstate <= next_wstate;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  always_comb begin
    frame_word1_o = 32'h0;
    frame_word1_o[MCCE_CODE_MSB:MCCE_CODE_LSB] = code;
    frame_word1_o[MCCE_RESTART_SAFE_BIT] = restart_safe;
  end

  assign mchk_o = mchk_q;
  assign microtrap_o = trap_q;
  assign mchk_code_o = code;
  assign irq_o = |(status & mask);
  assign s_axi_awready_o = (wstate == MCCE_W_IDLE) && !aw_held;
  assign s_axi_wready_o = (wstate == MCCE_W_IDLE) && !w_held;
  assign s_axi_bvalid_o = (wstate == MCCE_W_RESP);
  assign s_axi_bresp_o = bresp;
  assign s_axi_arready_o = !rvalid;
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rdata_o = rdata;
  assign s_axi_rresp_o = rresp;
endmodule : mcce_cause_encoder

// >>> tb/mcce_cause_encoder_properties.sv
// Port-level properties of the machine-check cause encoder.
// Assumes one clock domain and a synchronous active-high reset.
module mcce_cause_encoder_properties
  import mcce_pkg::*;
#(
  parameter int STALL_TIMEOUT_CYC = MCCE_STALL_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Detection inputs
  input wire logic mm_probe_valid_i,
  input wire logic mm_probe_status_known_i,
  input wire logic mm_fault_active_i,
  input wire logic irq_id_valid_i,
  input wire logic [5:0] interrupt_summary_reg_i,
  input wire logic irq_between_instr_i,
  input wire logic irq_mid_instr_i,
  input wire logic impossible_dispatch_i,
  input wire logic string_move_instr_i,
  input wire logic [1:0] string_move_state_i,
  input wire logic async_hw_error_i,
  input wire logic sync_hw_error_i,
  input wire logic xlate_hit_i,
  input wire logic xlate_tag_parity_err_i,
  input wire logic xlate_pte_parity_err_i,
  input wire logic exec_stage_three_stall_i,
  input wire logic exec_stage_four_stall_i,
  input wire logic field_queue_stall_i,
  input wire logic instr_queue_stall_i,
  // Frame outputs
  input wire logic mchk_o,
  input wire logic microtrap_o,
  input wire logic [7:0] mchk_code_o,
  input wire logic [31:0] frame_word1_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  logic c_mm, c_irq, c_mv, c_tb, c_any, stall_any, hi;
  int unsigned run;
  assign c_mm = mm_probe_valid_i && !mm_probe_status_known_i && mm_fault_active_i;
  assign c_irq = irq_id_valid_i && (interrupt_summary_reg_i >= MCCE_IRQ_ID_LIMIT)
    && (irq_between_instr_i || irq_mid_instr_i);
  assign c_mv = string_move_instr_i && (string_move_state_i == MCCE_MOVE_ILLEGAL);
  assign c_tb = xlate_hit_i && (xlate_tag_parity_err_i || xlate_pte_parity_err_i);
  assign stall_any = exec_stage_three_stall_i || exec_stage_four_stall_i
    || field_queue_stall_i || instr_queue_stall_i;
  assign hi = async_hw_error_i || sync_hw_error_i || c_tb || stall_any;
  assign c_any = c_mm || c_irq || c_mv || c_tb || impossible_dispatch_i || async_hw_error_i
    || sync_hw_error_i;
  // Length of the current unbroken stall, saturating
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || !stall_any) begin
      run <= 0;
    end else if (run < 32'hffff) begin
      run <= run + 1;
    end
  end
  sequence s_report(logic [7:0] c);
    mchk_o && (mchk_code_o == c);
  endsequence
  property p_frame_code;
    (frame_word1_o[23:16] == mchk_code_o) && (frame_word1_o[15:8] == 8'h00)
      && (frame_word1_o[31:24] == 8'h00) && (frame_word1_o[6:0] == 7'h00)
      && (mchk_code_o <= MCCE_SYNC_FAULT_CAUSE);
  endproperty
  a_frame_code: assert property (p_frame_code) else $error("frame code field wrong");
  property p_mm_fwd;
    // A stall ending this cycle may still expire the watchdog
    c_mm && !hi && !$past(stall_any) |=> s_report(MCCE_MM_STATUS_UNKNOWN_CAUSE);
  endproperty
  a_mm_fwd: assert property (p_mm_fwd) else $error("probe status cause missing");
  property p_mm_back;
    s_report(MCCE_MM_STATUS_UNKNOWN_CAUSE) |-> $past(c_mm);
  endproperty
  a_mm_back: assert property (p_mm_back) else $error("probe cause without fault");
  property p_irq_back;
    s_report(MCCE_BAD_IRQ_ID_CAUSE) |-> $past(c_irq);
  endproperty
  a_irq_back: assert property (p_irq_back) else $error("bad id cause unqualified");
  property p_dispatch_back;
    s_report(MCCE_IMPOSSIBLE_DISPATCH_CAUSE) |-> $past(impossible_dispatch_i);
  endproperty
  a_dispatch_back: assert property (p_dispatch_back) else $error("dispatch cause wrong");
  property p_move_back;
    s_report(MCCE_STRING_MOVE_STATE_CAUSE) |-> $past(c_mv);
  endproperty
  a_move_back: assert property (p_move_back) else $error("string state cause wrong");
  property p_any;
    c_any |=> mchk_o;
  endproperty
  a_any: assert property (p_any) else $error("detected fault gave no check");
  property p_async;
    async_hw_error_i |=> s_report(MCCE_ASYNC_FAULT_CAUSE);
  endproperty
  a_async: assert property (p_async) else $error("async cause missing");
  property p_sync;
    sync_hw_error_i && !async_hw_error_i && !c_tb && !stall_any && !$past(stall_any)
      |=> s_report(MCCE_SYNC_FAULT_CAUSE);
  endproperty
  a_sync: assert property (p_sync) else $error("sync cause missing");
  property p_tb;
    c_tb |=> microtrap_o ##0 s_report(MCCE_ASYNC_FAULT_CAUSE);
  endproperty
  a_tb: assert property (p_tb) else $error("parity hit gave no microtrap");
  property p_stall;
    stall_any && (run == STALL_TIMEOUT_CYC - 1) |-> ##[1:4] s_report(MCCE_ASYNC_FAULT_CAUSE);
  endproperty
  a_stall: assert property (p_stall) else $error("stall timeout not reported");
endmodule : mcce_cause_encoder_properties

bind mcce_cause_encoder mcce_cause_encoder_properties #(
  .STALL_TIMEOUT_CYC(STALL_TIMEOUT_CYC)
) u_mcce_cause_encoder_properties (.*);

// >>> tb/test_machine_check_cause_encoder.sv
// Self-checking bench for the machine-check cause encoder.
// Assumes the encoder alone, driven directly and over AXI4-Lite.
module test_machine_check_cause_encoder
  import mcce_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Short timeout keeps stall runs brief
  localparam int STC = 8;
  logic clk_sys_i, reset_i, mm_probe_valid_i, mm_probe_status_known_i, mm_fault_active_i;
  logic irq_id_valid_i, irq_between_instr_i, irq_mid_instr_i, impossible_dispatch_i;
  logic string_move_instr_i, async_hw_error_i, sync_hw_error_i, xlate_hit_i;
  logic xlate_tag_parity_err_i, xlate_pte_parity_err_i, exec_stage_three_stall_i;
  logic exec_stage_four_stall_i, field_queue_stall_i, instr_queue_stall_i;
  logic instr_start_i, arch_state_write_i, mchk_o, microtrap_o, irq_o;
  logic [5:0] interrupt_summary_reg_i;
  logic [1:0] string_move_state_i, s_axi_bresp_o, s_axi_rresp_o, resp;
  logic [7:0] mchk_code_o, s_axi_awaddr_i, s_axi_araddr_i, last;
  logic [31:0] frame_word1_o, s_axi_wdata_i, s_axi_rdata_o, rdat;
  logic [3:0] s_axi_wstrb_i, stv;
  logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
  int num_errors, cmp_count, cyc;
  assign {instr_queue_stall_i, field_queue_stall_i, exec_stage_four_stall_i,
    exec_stage_three_stall_i} = stv;
  mcce_cause_encoder #(.STALL_TIMEOUT_CYC(STC)) u_mcce_cause_encoder (.*);
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("Checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic put(input logic [15:0] m, input logic [5:0] id, input logic [1:0] s);
    mm_probe_valid_i <= m[0];
    mm_probe_status_known_i <= !m[0] || m[14];
    mm_fault_active_i <= m[1];
    irq_id_valid_i <= m[2];
    irq_between_instr_i <= m[3];
    irq_mid_instr_i <= m[4];
    impossible_dispatch_i <= m[5];
    string_move_instr_i <= m[6];
    async_hw_error_i <= m[7];
    sync_hw_error_i <= m[8];
    xlate_hit_i <= m[9];
    xlate_tag_parity_err_i <= m[10];
    xlate_pte_parity_err_i <= m[11];
    arch_state_write_i <= m[12];
    instr_start_i <= m[13];
    interrupt_summary_reg_i <= id;
    string_move_state_i <= s;
  endtask : put
  // One cycle of detection inputs, then the frame one edge later
  task automatic run(input logic [15:0] m, input logic [5:0] id, input logic [1:0] s,
      input logic [7:0] e);
    @(posedge clk_sys_i);
    put(m, id, s);
    @(posedge clk_sys_i);
    put(16'h0000, 6'h00, 2'h0);
    #1;
    if (e != 8'h00) last = e;
    chk("mchk", 32'(mchk_o), 32'(e != 8'h00));
    chk("trap", 32'(microtrap_o), 32'(m[9] && (m[10] || m[11])));
    chk("code", 32'(mchk_code_o), 32'(last));
    chk("frame", frame_word1_o & 32'hffffff7f, 32'(last) << 16);
  endtask : run
  // Holds valid until its own handshake; bready stays up until bvalid
  task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] re);
    logic ha, hw, hb;
    @(posedge clk_sys_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      #1;
      ha = s_axi_awvalid_i && s_axi_awready_o;
      hw = s_axi_wvalid_i && s_axi_wready_o;
      hb = s_axi_bvalid_o;
      resp = s_axi_bresp_o;
      @(posedge clk_sys_i);
      if (ha) s_axi_awvalid_i <= 1'b0;
      if (hw) s_axi_wvalid_i <= 1'b0;
    end
    s_axi_bready_i <= 1'b0;
    chk("bresp", 32'(resp), 32'(re));
  endtask : wchk
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re);
    logic g, h;
    @(posedge clk_sys_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    h = 1'b0;
    while (!h) begin
      #1;
      g = s_axi_arvalid_i && s_axi_arready_o;
      h = s_axi_rvalid_o;
      rdat = s_axi_rdata_o;
      resp = s_axi_rresp_o;
      @(posedge clk_sys_i);
      if (g) s_axi_arvalid_i <= 1'b0;
    end
    s_axi_rready_i <= 1'b0;
    chk("rdata", rdat, e);
    chk("rresp", 32'(resp), 32'(re));
  endtask : rchk
  // Holds one stall source n cycles and counts reports
  task automatic stall(input int i, input int n, input int e);
    int cnt;
    cnt = 0;
    for (int j = 0; j < n + 5; j++) begin
      @(posedge clk_sys_i);
      stv <= (j < n) ? 4'(1 << i) : 4'h0;
      #1;
      if (mchk_o === 1'b1 && mchk_code_o === MCCE_ASYNC_FAULT_CAUSE) cnt++;
    end
    chk("stall_reports", 32'(cnt), 32'(e));
  endtask : stall
  initial begin
    clk_sys_i = 1'b0;
    reset_i = 1'b1;
    last = 8'h00;
    stv = 4'h0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
    s_axi_wstrb_i = 4'hf;
    put(16'h0000, 6'h00, 2'h0);
    repeat (6) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    for (int a = 0; a < 16; a += 4) rchk(8'(a), 32'h0, MCCE_RESP_OKAY);
    rchk(MCCE_REG_TIMEOUT, 32'(STC), MCCE_RESP_OKAY);
    rchk(8'h20, 32'h0, MCCE_RESP_SLVERR);
    wchk(8'h20, 32'hffffffff, MCCE_RESP_SLVERR);
    run(16'h0003, 6'h00, 2'h0, 8'h01);
    run(16'h0001, 6'h00, 2'h0, 8'h00);
    run(16'h4003, 6'h00, 2'h0, 8'h00);
    run(16'h000c, 6'h3f, 2'h0, 8'h02);
    run(16'h0014, 6'h20, 2'h0, 8'h02);
    run(16'h0004, 6'h3f, 2'h0, 8'h00);
    run(16'h000c, 6'h1f, 2'h0, 8'h00);
    run(16'h0020, 6'h00, 2'h0, 8'h03);
    run(16'h0040, 6'h00, 2'h3, 8'h04);
    for (int s = 0; s < 3; s++) run(16'h0040, 6'h00, 2'(s), 8'h00);
    run(16'h0080, 6'h00, 2'h0, 8'h05);
    run(16'h0100, 6'h00, 2'h0, 8'h06);
    run(16'h0600, 6'h00, 2'h0, 8'h05);
    run(16'h0100, 6'h00, 2'h0, 8'h06);
    run(16'h0a00, 6'h00, 2'h0, 8'h05);
    run(16'h0c00, 6'h00, 2'h0, 8'h00);
    run(16'h01a0, 6'h00, 2'h0, 8'h05);
    run(16'h0103, 6'h00, 2'h0, 8'h06);
    run(16'h2000, 6'h00, 2'h0, 8'h00);
    run(16'h0020, 6'h00, 2'h0, 8'h03);
    chk("restart_safe", 32'(frame_word1_o[7]), 32'h1);
    run(16'h2000, 6'h00, 2'h0, 8'h00);
    run(16'h1020, 6'h00, 2'h0, 8'h03);
    chk("restart_safe", 32'(frame_word1_o[7]), 32'h0);
    wchk(MCCE_REG_CAUSE, 32'hffffffff, MCCE_RESP_OKAY);
    rchk(MCCE_REG_CAUSE, 32'h00030000, MCCE_RESP_OKAY);
    rchk(MCCE_REG_STATUS, 32'h3, MCCE_RESP_OKAY);
    chk("irq", 32'(irq_o), 32'h0);
    wchk(MCCE_REG_MASK, 32'h1, MCCE_RESP_OKAY);
    chk("irq", 32'(irq_o), 32'h1);
    wchk(MCCE_REG_STATUS, 32'h1, MCCE_RESP_OKAY);
    chk("irq", 32'(irq_o), 32'h0);
    wchk(MCCE_REG_MASK, 32'h7, MCCE_RESP_OKAY);
    rchk(MCCE_REG_MASK, 32'h7, MCCE_RESP_OKAY);
    chk("irq", 32'(irq_o), 32'h1);
    wchk(MCCE_REG_STATUS, 32'h2, MCCE_RESP_OKAY);
    rchk(MCCE_REG_STATUS, 32'h0, MCCE_RESP_OKAY);
    chk("irq", 32'(irq_o), 32'h0);
    wchk(MCCE_REG_FLAGS, 32'h0, MCCE_RESP_OKAY);
    rchk(MCCE_REG_FLAGS, 32'h1, MCCE_RESP_OKAY);
    wchk(MCCE_REG_FLAGS, 32'h1, MCCE_RESP_OKAY);
    rchk(MCCE_REG_FLAGS, 32'h0, MCCE_RESP_OKAY);
    stall(0, STC - 1, 0);
    stall(0, STC, 1);
    for (int i = 1; i < 4; i++) stall(i, STC + 3, 1);
    rchk(MCCE_REG_FLAGS, 32'h2, MCCE_RESP_OKAY);
    chk("irq", 32'(irq_o), 32'h1);
    wchk(MCCE_REG_FLAGS, 32'h2, MCCE_RESP_OKAY);
    rchk(MCCE_REG_FLAGS, 32'h0, MCCE_RESP_OKAY);
    test_done();
  end
endmodule : test_machine_check_cause_encoder
